// [can_tx_status_pkg.sv]
// Purpose: Shared constants and carriers for the transmit buffer status block.
// Assumes: 32-bit APB with word-aligned registers.
// Notes:   Offsets are byte addresses.
package can_tx_status_pkg;

  localparam int unsigned NUM_BUFS = 3;

  localparam logic [11:0] OFF_TX_FLAG      = 12'h000;
  localparam logic [11:0] OFF_TX_IRQ_EN    = 12'h004;
  localparam logic [11:0] OFF_TX_ABORT_REQ = 12'h008;
  localparam logic [11:0] OFF_TX_ABORT_ACK = 12'h00c;
  localparam logic [11:0] OFF_MODE_CTRL    = 12'h010;
  localparam logic [11:0] OFF_MODE_STATUS  = 12'h014;

  localparam int unsigned MODE_INIT_REQ_BIT    = 0;
  localparam int unsigned MODE_LISTEN_BIT      = 1;
  localparam int unsigned STATUS_INIT_ACK_BIT  = 0;
  localparam int unsigned STATUS_TX_ACTIVE_BIT = 1;

  localparam logic [2:0] RST_EMPTY_FLAGS = 3'h7;
  localparam logic [2:0] RST_IRQ_ENABLES = 3'h0;
  localparam logic [2:0] RST_ABORT_REQ   = 3'h0;
  localparam logic [2:0] RST_ABORT_ACK   = 3'h0;
  localparam logic [1:0] RST_MODE_CTRL   = 2'h1;

  // Per-buffer events from the frame engine, each a one-cycle pulse.
  typedef struct packed {
    logic [2:0] sent;
    logic [2:0] abort_done;
    logic [2:0] started;
  } engine_evt_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

endpackage

// [can_tx_buffer_status_abort.sv]
// Purpose: Transmit buffer empty flags, interrupt enables and abort handshake.
// Assumes: One 125 MHz clock; engine events are synchronous one-cycle pulses.
// Notes:   APB answers with zero wait states; pslverr on unmapped addresses.
//
// How it works
// - One empty flag per buffer; 1 means empty and not scheduled.
// - Successful transmission sets the buffer's empty flag.
// - A successful abort also sets the buffer's empty flag.
// - Interrupt stays high while some empty flag and its enable are set.
// - Clearing an empty flag clears that buffer's abort acknowledge.
// - Setting an empty flag for any cause clears its abort request.
// - Listen-only mode ignores flag clears and starts no transmission.
// - Buffer content access is blocked while the buffer is scheduled.
// - Writing 1 clears an empty flag, writing 0 does nothing; reads anytime.
// - Initialization mode holds all four registers at reset values.
// - One empty interrupt enable per buffer; 0 masks that buffer.
// - Abort granted only before start or after lost arbitration or error.
// - Granted abort sets empty and acknowledge flags and may interrupt.
// - Abort request is set by software, cleared only by hardware.
// - Abort acknowledge is read-only: 1 aborted, 0 sent.
`timescale 1ns/1ps
`default_nettype none

module can_tx_buffer_status_abort
  import can_tx_status_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [11:0]         paddr_i,
  input  wire logic [31:0]         pwdata_i,
  input  wire logic [3:0]          pstrb_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  input  wire logic                init_mode_acknowledge_i,
  input  wire engine_evt_s         engine_evt_i,
  input  wire logic [NUM_BUFS-1:0] tx_failed_i,
  output logic      [NUM_BUFS-1:0] tx_schedule_o,
  output logic      [NUM_BUFS-1:0] abort_grant_o,
  output logic      [NUM_BUFS-1:0] buf_access_block_o,
  output logic                     init_mode_request_o,
  output logic                     tx_irq_o
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [NUM_BUFS-1:0] buffer_empty_flag_ff;
  logic [NUM_BUFS-1:0] empty_irq_enable_ff;
  logic [NUM_BUFS-1:0] abort_request_ff;
  logic [NUM_BUFS-1:0] abort_acknowledge_ff;
  logic [NUM_BUFS-1:0] in_flight_ff;
  logic [NUM_BUFS-1:0] nxt_empty;
  logic [NUM_BUFS-1:0] nxt_abort_req;
  logic [NUM_BUFS-1:0] nxt_abort_ack;
  logic [NUM_BUFS-1:0] set_empty;
  logic [NUM_BUFS-1:0] clr_empty;
  logic [NUM_BUFS-1:0] grant;
  logic                init_req_ff;
  logic                listen_ff;
  logic                init_active;
  logic                wr_open;
  logic                wr_acc;
  logic                rd_acc;
  logic                mapped;
  logic [31:0]         nxt_rdata;

  apb_req_s req;
  assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
                 paddr: paddr_i, pwdata: pwdata_i};

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign init_active = init_req_ff & init_mode_acknowledge_i;
  // Writes other than mode control need both request and acknowledge low; a half-way transition blocks them.
  assign wr_open = ~init_req_ff & ~init_mode_acknowledge_i;
  assign mapped  = (req.paddr == OFF_TX_FLAG) || (req.paddr == OFF_TX_IRQ_EN) ||
                   (req.paddr == OFF_TX_ABORT_REQ) || (req.paddr == OFF_TX_ABORT_ACK) ||
                   (req.paddr == OFF_MODE_CTRL) || (req.paddr == OFF_MODE_STATUS);
  assign wr_acc  = req.psel & req.penable & req.pwrite & mapped & pstrb_i[0];
  assign rd_acc  = req.psel & ~req.penable & ~req.pwrite;

  // ****************************************************************
  // Flag update per buffer
  // ****************************************************************
  genvar b;
  generate
    for (b = 0; b < NUM_BUFS; b++) begin : g_buf
      // Abort only wins while the buffer is idle or its attempt just failed.
      assign grant[b] = abort_request_ff[b] & ~buffer_empty_flag_ff[b] &
                        (~in_flight_ff[b] | tx_failed_i[b]) & ~engine_evt_i.sent[b];
      assign set_empty[b] = engine_evt_i.sent[b] | grant[b] | engine_evt_i.abort_done[b];
      // Listen-only mode refuses the clear, so nothing gets scheduled.
      assign clr_empty[b] = wr_acc & wr_open & ~listen_ff & (req.paddr == OFF_TX_FLAG) &
                            req.pwdata[b];
      // Hardware set beats a same-cycle software clear so no completion is lost.
      assign nxt_empty[b] = set_empty[b] | (buffer_empty_flag_ff[b] & ~clr_empty[b]);
      assign nxt_abort_req[b] = set_empty[b] ? 1'b0 :
                                (abort_request_ff[b] | (wr_acc & wr_open &
                                 (req.paddr == OFF_TX_ABORT_REQ) & req.pwdata[b] &
                                 ~buffer_empty_flag_ff[b]));
      assign nxt_abort_ack[b] = (grant[b] | engine_evt_i.abort_done[b]) ? 1'b1 :
                                (engine_evt_i.sent[b] ? 1'b0 :
                                 (clr_empty[b] ? 1'b0 : abort_acknowledge_ff[b]));
    end
  endgenerate

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i || init_active) begin
      buffer_empty_flag_ff <= RST_EMPTY_FLAGS;
      abort_request_ff     <= RST_ABORT_REQ;
      abort_acknowledge_ff <= RST_ABORT_ACK;
    end else begin
      buffer_empty_flag_ff <= nxt_empty;
      abort_request_ff     <= nxt_abort_req;
      abort_acknowledge_ff <= nxt_abort_ack;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || init_active) begin
      empty_irq_enable_ff <= RST_IRQ_ENABLES;
    end else if (wr_acc && wr_open && req.paddr == OFF_TX_IRQ_EN) begin
      empty_irq_enable_ff <= req.pwdata[NUM_BUFS-1:0];
    end
  end

  // Mode control stays writable in initialization mode, else it could never be left.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      {listen_ff, init_req_ff} <= RST_MODE_CTRL;
    end else if (wr_acc && req.paddr == OFF_MODE_CTRL) begin
      init_req_ff <= req.pwdata[MODE_INIT_REQ_BIT];
      listen_ff   <= req.pwdata[MODE_LISTEN_BIT];
    end
  end

  // An attempt is in flight from its start pulse until it ends or the buffer empties.
  always_ff @(posedge clk_i) begin
    if (srst_i || init_active) begin
      in_flight_ff <= '0;
    end else begin
      in_flight_ff <= (in_flight_ff | engine_evt_i.started) & ~nxt_empty & ~tx_failed_i;
    end
  end

  // ****************************************************************
  // Outputs toward the engine and interrupt
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_schedule_o      <= '0;
      abort_grant_o      <= '0;
      buf_access_block_o <= '0;
      tx_irq_o           <= 1'b0;
    end else begin
      tx_schedule_o      <= listen_ff ? '0 : ~nxt_empty;
      abort_grant_o      <= grant;
      buf_access_block_o <= ~nxt_empty;
      tx_irq_o           <= |(nxt_empty & empty_irq_enable_ff);
    end
  end

  // ****************************************************************
  // Read data and answer
  // ****************************************************************
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (req.paddr)
      OFF_TX_FLAG:      nxt_rdata[NUM_BUFS-1:0] = buffer_empty_flag_ff;
      OFF_TX_IRQ_EN:    nxt_rdata[NUM_BUFS-1:0] = empty_irq_enable_ff;
      OFF_TX_ABORT_REQ: nxt_rdata[NUM_BUFS-1:0] = abort_request_ff;
      OFF_TX_ABORT_ACK: nxt_rdata[NUM_BUFS-1:0] = abort_acknowledge_ff;
      OFF_MODE_CTRL: begin
        nxt_rdata[MODE_INIT_REQ_BIT] = init_req_ff;
        nxt_rdata[MODE_LISTEN_BIT]   = listen_ff;
      end
      OFF_MODE_STATUS: begin
        nxt_rdata[STATUS_INIT_ACK_BIT]  = init_mode_acknowledge_i;
        nxt_rdata[STATUS_TX_ACTIVE_BIT] = |in_flight_ff;
      end
      default:          nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Setup phase registers the answer, so every access has exactly one access cycle.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= req.psel & ~req.penable;
      pslverr_o <= req.psel & ~req.penable & ~mapped;
      if (rd_acc) begin
        prdata_o <= nxt_rdata;
      end
    end
  end

  assign init_mode_request_o = init_req_ff;

endmodule

`default_nettype wire

// [can_tx_engine_model.sv]
// Purpose: Frame engine stand-in on the far side of the status block.
// Assumes: Bench commands last one cycle.
// Notes:   Acts only on scheduled buffers, as a real engine must.
`timescale 1ns/1ps
`default_nettype none
module can_tx_engine_model import can_tx_status_pkg::*; (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire engine_evt_s cmd_i,
  input  wire logic [2:0]  fail_i,
  input  wire logic [2:0]  sched_i,
  input  wire logic        req_i,
  output var engine_evt_s  evt_o,
  output logic [2:0]       failed_o,
  output logic             ack_o
);
  always_ff @(posedge clk_i) begin
    evt_o    <= srst_i ? '0 : cmd_i & {3{sched_i}};
    failed_o <= srst_i ? 3'h0 : fail_i & sched_i;
    ack_o    <= srst_i ? 1'b0 : req_i;
  end
endmodule
`default_nettype wire

// [can_tx_status_properties.sv]
// Purpose: Port properties of the transmit status block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Registered outputs trail their cause by one edge.
`timescale 1ns/1ps
`default_nettype none
module can_tx_status_properties import can_tx_status_pkg::*; (
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire engine_evt_s engine_evt_i,
  input wire logic [2:0]  tx_schedule_o,
  input wire logic [2:0]  abort_grant_o,
  input wire logic [2:0]  buf_access_block_o,
  input wire logic        init_mode_request_o,
  input wire logic        init_mode_acknowledge_i,
  input wire logic        tx_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  chk_ready_one: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  chk_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  chk_sent_frees: assert property (|engine_evt_i.sent |=> ##1
    (tx_schedule_o & $past(engine_evt_i.sent, 2)) == 3'h0) else $error("sent buffer busy");
  chk_irq_flag: assert property (tx_irq_o |-> buf_access_block_o != 3'h7)
    else $error("irq with no empty buffer");
  chk_sched_blocked: assert property ((tx_schedule_o & ~buf_access_block_o) == 3'h0)
    else $error("scheduled buffer not blocked");
  chk_grant_busy: assert property (|abort_grant_o |->
    (abort_grant_o & ~$past(buf_access_block_o)) == 3'h0) else $error("grant on empty buffer");
  chk_grant_frees: assert property (|abort_grant_o |=>
    (buf_access_block_o & $past(abort_grant_o)) == 3'h0) else $error("aborted buffer busy");
  chk_init_hold: assert property ((init_mode_request_o && init_mode_acknowledge_i) [*2]
    |=> buf_access_block_o == 3'h0 && !tx_irq_o) else $error("init mode not held");
endmodule
bind can_tx_buffer_status_abort can_tx_status_properties props (.clk_i(clk_i),
  .srst_i(srst_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_irq_o(tx_irq_o),
  .engine_evt_i(engine_evt_i), .tx_schedule_o(tx_schedule_o),
  .abort_grant_o(abort_grant_o), .buf_access_block_o(buf_access_block_o),
  .init_mode_request_o(init_mode_request_o),
  .init_mode_acknowledge_i(init_mode_acknowledge_i));
`default_nettype wire

// [testbench.sv]
// Purpose: Self-checking bench for the transmit status block.
// Assumes: Zero-wait slave; the engine stand-in acts on scheduled buffers.
// Notes:   Strobe bit 0 stays high so every write lands.
`timescale 1ns/1ps
`default_nettype none
module testbench import can_tx_status_pkg::*; ;
  logic        clk_i = 1'b0;
  logic        srst_i, psel, pen, pwr, pready, perr, err, req, ack, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [2:0]  fail, failed, sched, grant, blk;
  engine_evt_s cmd, evt;
  int          num_errors = 0;
  int          compares = 0;
  can_tx_buffer_status_abort dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .init_mode_acknowledge_i(ack),
    .engine_evt_i(evt), .tx_failed_i(failed), .tx_schedule_o(sched), .abort_grant_o(grant),
    .buf_access_block_o(blk), .init_mode_request_o(req), .tx_irq_o(irq));
  can_tx_engine_model engine (.clk_i(clk_i), .srst_i(srst_i), .cmd_i(cmd), .fail_i(fail),
    .sched_i(sched), .req_i(req), .evt_o(evt), .failed_o(failed), .ack_o(ack));
  task automatic stop_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rdata = prdata;
    err   = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
    // One idle edge keeps a following call from re-driving psel in this time step.
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    wr(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask
  // Engine pulses last one cycle; three idle edges let registered outputs settle.
  task automatic pulse(input engine_evt_s c, input logic [2:0] f);
    cmd  <= c;
    fail <= f;
    @(posedge clk_i);
    cmd  <= '0;
    fail <= 3'h0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic t_reset;
    rd(OFF_TX_FLAG, 32'h7);
    rd(OFF_TX_IRQ_EN, 32'h0);
    wr(1'b1, OFF_TX_FLAG, 32'h1);
    rd(OFF_TX_FLAG, 32'h7);
    wr(1'b1, 12'h018, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(1'b1, OFF_MODE_CTRL, 32'h0);
    chk({31'h0, req}, 32'h0);
    repeat (2) @(posedge clk_i);
  endtask
  task automatic t_send;
    wr(1'b1, OFF_TX_IRQ_EN, 32'h1);
    wr(1'b1, OFF_TX_FLAG, 32'h0);
    chk({31'h0, irq}, 32'h1);
    // Buffer 0 counts as fully loaded here, so clearing its flag schedules it.
    wr(1'b1, OFF_TX_FLAG, 32'h1);
    rd(OFF_TX_FLAG, 32'h6);
    chk({31'h0, irq}, 32'h0);
    chk({29'h0, blk}, 32'h1);
    chk({29'h0, sched}, 32'h1);
    pulse(9'h040, 3'h0);
    rd(OFF_TX_FLAG, 32'h7);
    rd(OFF_TX_ABORT_ACK, 32'h0);
  endtask
  task automatic t_abort;
    wr(1'b1, OFF_TX_FLAG, 32'h2);
    repeat (2) @(posedge clk_i);
    pulse(9'h002, 3'h0);
    // Software aims the abort at the scheduled buffer 1; bit 0 shows the empty one is refused.
    wr(1'b1, OFF_TX_ABORT_REQ, 32'h3);
    wr(1'b1, OFF_TX_ABORT_REQ, 32'h0);
    rd(OFF_TX_ABORT_REQ, 32'h2);
    rd(OFF_TX_FLAG, 32'h5);
    pulse(9'h000, 3'h2);
    rd(OFF_TX_FLAG, 32'h7);
    rd(OFF_TX_ABORT_ACK, 32'h2);
    rd(OFF_TX_ABORT_REQ, 32'h0);
    wr(1'b1, OFF_TX_FLAG, 32'h2);
    rd(OFF_TX_ABORT_ACK, 32'h0);
  endtask
  task automatic t_listen;
    wr(1'b1, OFF_MODE_CTRL, 32'h2);
    wr(1'b1, OFF_TX_FLAG, 32'h4);
    rd(OFF_TX_FLAG, 32'h5);
    chk({29'h0, sched}, 32'h0);
    wr(1'b1, OFF_MODE_CTRL, 32'h1);
    repeat (2) @(posedge clk_i);
    wr(1'b1, OFF_TX_IRQ_EN, 32'h7);
    rd(OFF_TX_IRQ_EN, 32'h0);
    rd(OFF_TX_FLAG, 32'h7);
  endtask
  initial forever #4 clk_i = ~clk_i;
  initial begin
    repeat (3000) @(posedge clk_i);
    num_errors++;
    stop_test;
  end
  initial begin
    {psel, pen, pwr, paddr, pwdata, cmd, fail} = '0;
    srst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset;
    t_send;
    t_abort;
    t_listen;
    stop_test;
  end
endmodule
`default_nettype wire
